// *** src/trb_defs.vh ***
// Offsets, field positions and constants of the telemetry read-back bank.
// Summary of operation
// - Status bit0 overvoltage, bit1 undervoltage comparator.
// - Status bit3 sense short, bit2 output short.
// - Latched restart causes in bits 15,12,11,10,9.
// - Latch-off flag bit7, causes bits 6,4,2,1,0.
// - Latched bit5 set on supply-off command.
// - Average current: 16-sample mean, bits 7:0.
// - Average voltage: 16-sample mean, bits 11:0.
`ifndef TRB_DEFS_VH
`define TRB_DEFS_VH
`define TRB_OFF_STATUS 8'h14
`define TRB_OFF_LATCHED 8'h16
`define TRB_OFF_INTR 8'h18
`define TRB_OFF_AVGI 8'h1A
`define TRB_OFF_AVGV 8'h1C
`define TRB_OFF_DAC 8'h5C
`define TRB_READ_PORT 8'h80
`define TRB_AVG_LOG2 4
`define TRB_ST_OV 0
`define TRB_ST_UV 1
`define TRB_ST_OSHORT 2
`define TRB_ST_SSHORT 3
`define TRB_ST_HI10 4
`define TRB_ST_BLEED 5
`define TRB_ST_OTP 9
`define TRB_ST_FSW 12
`define TRB_ST_DIS 13
`define TRB_ST_READY 14
`define TRB_ST_INTEN 15
`define TRB_LA_BPS 0
`define TRB_LA_LO_UV 1
`define TRB_LA_LO_OV 2
`define TRB_LA_LO_SSH 4
`define TRB_LA_PSUOFF 5
`define TRB_LA_LO_OVL 6
`define TRB_LA_LO 7
`define TRB_LA_AR_UV 9
`define TRB_LA_AR_OV 10
`define TRB_LA_AR_OSH 11
`define TRB_LA_AR_SSH 12
`define TRB_LA_AR_OVL 15
`define TRB_INT_MASK_SHIFT 8
`endif

// *** src/trb_average.v ***
// Sliding mean over the last sixteen samples of one measurement.
`timescale 1ns/1ps
`default_nettype none
module trb_average #(
  parameter WIDTH = 8,
  parameter LOG2N = 4
) (
  input wire clk,
  input wire rst,
  input wire sampleValid,
  input wire [WIDTH-1:0] sampleIn,
  output reg [WIDTH-1:0] meanOut
);
  localparam N = 1 << LOG2N;
  localparam SW = WIDTH + LOG2N;
  reg [WIDTH-1:0] histReg [0:N-1];
  reg [LOG2N-1:0] ptrReg;
  reg [SW-1:0] sumReg;
  wire [SW-1:0] sumNext;
  integer i;
  // Running sum: add the new sample, drop the oldest, so no adder tree is needed.
  assign sumNext = sumReg + {{LOG2N{1'b0}}, sampleIn} - {{LOG2N{1'b0}}, histReg[ptrReg]};
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < N; i = i + 1) begin
        histReg[i] <= {WIDTH{1'b0}};
      end
      ptrReg <= {LOG2N{1'b0}};
      sumReg <= {SW{1'b0}};
      meanOut <= {WIDTH{1'b0}};
    end else if (sampleValid) begin
      histReg[ptrReg] <= sampleIn;
      ptrReg <= ptrReg + 1'b1;
      sumReg <= sumNext;
      meanOut <= sumNext[SW-1:LOG2N];
    end
  end
endmodule // trb_average
`default_nettype wire

// *** src/trb_telemetry_bank.v ***
// Telemetry read-back bank: status, latched faults, interrupts, averages.
`timescale 1ns/1ps
`default_nettype none
`include "trb_defs.vh"
module trb_telemetry_bank #(
  parameter IW = 8,
  parameter VW = 12
) (
  input wire clk,
  input wire rst,
  input wire overvoltageCompareFlag,
  input wire undervoltageCompareFlag,
  input wire outputShortFlag,
  input wire sensePinShortFlag,
  input wire outputAbove110Flag,
  input wire weakBleederFlag,
  input wire overTempFlag,
  input wire highSwitchFreqFlag,
  input wire dischargeFlag,
  input wire systemReadyFlag,
  input wire interruptEnableFlag,
  input wire overloadRestartCause,
  input wire senseShortRestartCause,
  input wire outputShortRestartCause,
  input wire overvoltageRestartCause,
  input wire undervoltageRestartCause,
  input wire overloadLatchoffCause,
  input wire senseShortLatchoffCause,
  input wire overvoltageLatchoffCause,
  input wire undervoltageLatchoffCause,
  input wire supplyPinLatchoffCause,
  input wire supplyOffCommand,
  input wire latchClear,
  input wire [6:0] interruptMask,
  input wire [15:0] voltageDacSetting,
  input wire currentSampleValid,
  input wire [IW-1:0] measuredCurrentWord,
  input wire voltageSampleValid,
  input wire [VW-1:0] measuredVoltageWord,
  input wire subAddrWrite,
  input wire [7:0] subAddr,
  output reg [15:0] readData,
  output reg readHit
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Fault pins come from analog comparators, so each passes two flops.
  localparam NS = 22;
  wire [NS-1:0] rawIn = {overvoltageCompareFlag, undervoltageCompareFlag, outputShortFlag,
    sensePinShortFlag, outputAbove110Flag, weakBleederFlag, overTempFlag, highSwitchFreqFlag,
    dischargeFlag, systemReadyFlag, interruptEnableFlag, overloadRestartCause,
    senseShortRestartCause, outputShortRestartCause, overvoltageRestartCause,
    undervoltageRestartCause, overloadLatchoffCause, senseShortLatchoffCause,
    overvoltageLatchoffCause, undervoltageLatchoffCause, supplyPinLatchoffCause, supplyOffCommand};
  reg [NS-1:0] syncAReg;
  reg [NS-1:0] syncBReg;
  always @(posedge clk) begin
    if (rst) begin
      syncAReg <= {NS{1'b0}};
      syncBReg <= {NS{1'b0}};
    end else begin
      syncAReg <= rawIn;
      syncBReg <= syncAReg;
    end
  end
  wire sOv = syncBReg[21];
  wire sUv = syncBReg[20];
  wire sOsh = syncBReg[19];
  wire sSsh = syncBReg[18];
  wire sHi10 = syncBReg[17];
  wire sBleed = syncBReg[16];
  wire sOtp = syncBReg[15];
  wire sFsw = syncBReg[14];
  wire sDis = syncBReg[13];
  wire sReady = syncBReg[12];
  wire sIntEn = syncBReg[11];
  // Cause inputs in latched-word order.
  wire [9:0] causeIn = syncBReg[10:1];
  wire sPsuOff = syncBReg[0];

  // ---------------------------------------------------------------
  // Instantaneous status word
  // ---------------------------------------------------------------
  reg [15:0] statusNext;
  always @* begin
    statusNext = 16'h0000;
    statusNext[`TRB_ST_OV] = sOv;
    statusNext[`TRB_ST_UV] = sUv;
    statusNext[`TRB_ST_OSHORT] = sOsh;
    statusNext[`TRB_ST_SSHORT] = sSsh;
    statusNext[`TRB_ST_HI10] = sHi10;
    statusNext[`TRB_ST_BLEED] = sBleed;
    statusNext[`TRB_ST_OTP] = sOtp;
    statusNext[`TRB_ST_FSW] = sFsw;
    statusNext[`TRB_ST_DIS] = sDis;
    statusNext[`TRB_ST_READY] = sReady;
    statusNext[`TRB_ST_INTEN] = sIntEn;
  end

  // ---------------------------------------------------------------
  // Latched fault word
  // ---------------------------------------------------------------
  // A new event in the clear cycle still sets its bit: set beats clear.
  reg [15:0] latchedReg;
  reg [15:0] latchSet;
  always @* begin
    latchSet = 16'h0000;
    latchSet[`TRB_LA_AR_OVL] = causeIn[9];
    latchSet[`TRB_LA_AR_SSH] = causeIn[8];
    latchSet[`TRB_LA_AR_OSH] = causeIn[7];
    latchSet[`TRB_LA_AR_OV] = causeIn[6];
    latchSet[`TRB_LA_AR_UV] = causeIn[5];
    latchSet[`TRB_LA_LO_OVL] = causeIn[4];
    latchSet[`TRB_LA_LO_SSH] = causeIn[3];
    latchSet[`TRB_LA_LO_OV] = causeIn[2];
    latchSet[`TRB_LA_LO_UV] = causeIn[1];
    latchSet[`TRB_LA_BPS] = causeIn[0];
    latchSet[`TRB_LA_LO] = |causeIn[4:0];
    latchSet[`TRB_LA_PSUOFF] = sPsuOff;
  end
  always @(posedge clk) begin
    if (rst) begin
      latchedReg <= 16'h0000;
    end else if (latchClear) begin
      latchedReg <= latchSet;
    end else begin
      latchedReg <= latchedReg | latchSet;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt word
  // ---------------------------------------------------------------
  // Bit 4 has no documented source and stays zero; bit 5 is any latch-off.
  reg [6:0] intCause;
  always @* begin
    intCause = {sReady, latchedReg[`TRB_LA_LO], 1'b0, sSsh, sOsh, sUv, sOv};
  end
  wire [15:0] intWord = {1'b0, interruptMask, 1'b0, intCause & interruptMask};

  // ---------------------------------------------------------------
  // Averages
  // ---------------------------------------------------------------
  wire [IW-1:0] avgCurrent;
  wire [VW-1:0] avgVoltage;
  reg [IW-1:0] curSyncA;
  reg [IW-1:0] curSyncB;
  reg [VW-1:0] volSyncA;
  reg [VW-1:0] volSyncB;
  reg [1:0] curVldReg;
  reg [1:0] volVldReg;
  // Sample words are captured two flops deep alongside their strobes.
  always @(posedge clk) begin
    if (rst) begin
      curSyncA <= {IW{1'b0}};
      curSyncB <= {IW{1'b0}};
      volSyncA <= {VW{1'b0}};
      volSyncB <= {VW{1'b0}};
      curVldReg <= 2'b00;
      volVldReg <= 2'b00;
    end else begin
      curSyncA <= measuredCurrentWord;
      curSyncB <= curSyncA;
      volSyncA <= measuredVoltageWord;
      volSyncB <= volSyncA;
      curVldReg <= {curVldReg[0], currentSampleValid};
      volVldReg <= {volVldReg[0], voltageSampleValid};
    end
  end
  trb_average #(.WIDTH(IW), .LOG2N(`TRB_AVG_LOG2)) uAvgI (
    .clk(clk),
    .rst(rst),
    .sampleValid(curVldReg[1]),
    .sampleIn(curSyncB),
    .meanOut(avgCurrent)
  );
  trb_average #(.WIDTH(VW), .LOG2N(`TRB_AVG_LOG2)) uAvgV (
    .clk(clk),
    .rst(rst),
    .sampleValid(volVldReg[1]),
    .sampleIn(volSyncB),
    .meanOut(avgVoltage)
  );

  // ---------------------------------------------------------------
  // Read-back port
  // ---------------------------------------------------------------
  // The sub-address is held, so repeated reads of the port return fresh data.
  reg [7:0] subAddrReg;
  reg [15:0] readNext;
  reg hitNext;
  always @(posedge clk) begin
    if (rst) begin
      subAddrReg <= 8'h00;
    end else if (subAddrWrite) begin
      subAddrReg <= subAddr;
    end
  end
  always @* begin
    readNext = 16'h0000;
    hitNext = 1'b1;
    case (subAddrReg)
      `TRB_OFF_STATUS: readNext = statusNext;
      `TRB_OFF_LATCHED: readNext = latchedReg;
      `TRB_OFF_INTR: readNext = intWord;
      `TRB_OFF_AVGI: readNext = {{(16-IW){1'b0}}, avgCurrent};
      `TRB_OFF_AVGV: readNext = {{(16-VW){1'b0}}, avgVoltage};
      `TRB_OFF_DAC: readNext = voltageDacSetting;
      default: hitNext = 1'b0;
    endcase
  end
  always @(posedge clk) begin
    if (rst) begin
      readData <= 16'h0000;
      readHit <= 1'b0;
    end else begin
      readData <= readNext;
      readHit <= hitNext;
    end
  end
endmodule // trb_telemetry_bank
`default_nettype wire

// *** tb/trb_bank_monitor.sv ***
// Port-level assertions for the telemetry read-back bank.
`timescale 1ns/1ps
`default_nettype none
module trb_bank_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic overvoltageCompareFlag,
  input wire logic undervoltageCompareFlag,
  input wire logic outputShortFlag,
  input wire logic sensePinShortFlag,
  input wire logic overloadRestartCause,
  input wire logic overloadLatchoffCause,
  input wire logic supplyOffCommand,
  input wire logic subAddrWrite,
  input wire logic [7:0] subAddr,
  input wire logic [15:0] readData
);
  // Status and latched checks wait five cycles after reset so that no pre-reset input history is judged.
  logic [7:0] selReg;
  logic [2:0] ageReg;
  logic warm;
  assign warm = ageReg > 3'h4;
  always_ff @(posedge clk) begin
    selReg <= rst ? 8'h00 : subAddrWrite ? subAddr : selReg;
    ageReg <= rst ? 3'h0 : ageReg + {2'h0, ageReg != 3'h7};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  status_comp_a: assert property (warm && $past(selReg) == 8'h14 |->
    readData[1:0] == {$past(undervoltageCompareFlag, 3), $past(overvoltageCompareFlag, 3)}) else $error("bad ov/uv");
  status_short_a: assert property (warm && $past(selReg) == 8'h14 |->
    readData[3:2] == {$past(sensePinShortFlag, 3), $past(outputShortFlag, 3)}) else $error("bad short bits");
  restart_cause_a: assert property (warm && $past(selReg) == 8'h16 && $past(overloadRestartCause, 4)
    |-> readData[15]) else $error("restart cause lost");
  latchoff_cause_a: assert property (warm && $past(selReg) == 8'h16 && $past(overloadLatchoffCause, 4)
    |-> readData[7:6] == 2'h3) else $error("latch-off cause lost");
  supply_off_a: assert property (warm && $past(selReg) == 8'h16 && $past(supplyOffCommand, 4)
    |-> readData[5]) else $error("supply-off flag lost");
  avg_current_a: assert property ($past(selReg) == 8'h1A |-> readData[15:8] == 8'h00)
    else $error("current high byte set");
  avg_voltage_a: assert property ($past(selReg) == 8'h1C |-> readData[15:12] == 4'h0)
    else $error("voltage top bits set");
  intr_gate_a: assert property ($past(selReg) == 8'h18 |-> (readData[6:0] & ~readData[14:8]) == 7'h00)
    else $error("masked cause shown");
endmodule // trb_bank_monitor
bind trb_telemetry_bank trb_bank_monitor u_trb_bank_monitor (.clk, .rst, .overvoltageCompareFlag,
  .undervoltageCompareFlag, .outputShortFlag, .sensePinShortFlag, .overloadRestartCause,
  .overloadLatchoffCause, .supplyOffCommand, .subAddrWrite, .subAddr, .readData);
`default_nettype wire

// *** tb/trb_host_model.sv ***
// Host-side model that selects a telemetry word and reads it back.
`timescale 1ns/1ps
`default_nettype none
module trb_host_model (
  input wire logic clk,
  input wire logic [15:0] readData,
  input wire logic readHit,
  output var logic subAddrWrite,
  output var logic [7:0] subAddr
);
  initial begin
    subAddrWrite = 1'h0;
    subAddr = 8'h00;
  end
  // The address is inverted once taken, so nothing may rely on it lingering.
  task automatic read_word(input logic [7:0] a, output logic [16:0] r);
    @(posedge clk);
    subAddrWrite <= 1'h1;
    subAddr <= a;
    @(posedge clk);
    subAddrWrite <= 1'h0;
    subAddr <= ~a;
    repeat (2) @(posedge clk);
    #1 r = {readHit, readData};
  endtask
endmodule // trb_host_model
`default_nettype wire

// *** tb/test_trb_telemetry_bank.sv ***
// Self-checking testbench of the telemetry read-back bank.
`timescale 1ns/1ps
`default_nettype none
module test_trb_telemetry_bank;
  logic clk, rst, clr, curVal, volVal;
  logic [10:0] st, cz;
  logic [6:0] mask;
  logic [15:0] dac;
  logic [7:0] curIn;
  logic [11:0] volIn;
  logic [16:0] got;
  wire logic sw, hit;
  wire logic [7:0] sa;
  wire logic [15:0] rd;
  int err_total = 0;
  int n_tests = 0;
  int stPos[11] = '{0, 1, 2, 3, 4, 5, 9, 12, 13, 14, 15};
  int czPos[11] = '{15, 12, 11, 10, 9, 6, 4, 2, 1, 0, 5};
  trb_telemetry_bank u_trb_telemetry_bank (.clk(clk), .rst(rst), .overvoltageCompareFlag(st[0]),
    .undervoltageCompareFlag(st[1]), .outputShortFlag(st[2]), .sensePinShortFlag(st[3]),
    .outputAbove110Flag(st[4]), .weakBleederFlag(st[5]), .overTempFlag(st[6]), .highSwitchFreqFlag(st[7]),
    .dischargeFlag(st[8]), .systemReadyFlag(st[9]), .interruptEnableFlag(st[10]),
    .overloadRestartCause(cz[0]), .senseShortRestartCause(cz[1]), .outputShortRestartCause(cz[2]),
    .overvoltageRestartCause(cz[3]), .undervoltageRestartCause(cz[4]), .overloadLatchoffCause(cz[5]),
    .senseShortLatchoffCause(cz[6]), .overvoltageLatchoffCause(cz[7]), .undervoltageLatchoffCause(cz[8]),
    .supplyPinLatchoffCause(cz[9]), .supplyOffCommand(cz[10]), .latchClear(clr), .interruptMask(mask),
    .voltageDacSetting(dac), .currentSampleValid(curVal), .measuredCurrentWord(curIn),
    .voltageSampleValid(volVal), .measuredVoltageWord(volIn), .subAddrWrite(sw), .subAddr(sa),
    .readData(rd), .readHit(hit));
  trb_host_model u_trb_host_model (.clk(clk), .readData(rd), .readHit(hit), .subAddrWrite(sw), .subAddr(sa));
  task automatic chk(input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [7:0] a, input logic [16:0] exp);
    u_trb_host_model.read_word(a, got);
    chk(exp);
  endtask
  task automatic t_status();
    // The reset value is taken a cycle after release, never in the edge's own time step.
    @(posedge clk);
    #1 got = {hit, rd};
    chk(17'h00000);
    for (int i = 0; i < 11; i++) begin
      st <= 11'h001 << i;
      repeat (4) @(posedge clk);
      check_word(8'h14, {1'h1, 16'h0001 << stPos[i]});
    end
    st <= 11'h000;
    check_word(8'h15, 17'h00000);
    check_word(8'h5C, {1'h1, dac});
  endtask
  task automatic t_latched();
    // Selecting the latched word first lets the monitor judge the very first cause.
    check_word(8'h16, 17'h10000);
    for (int i = 0; i < 11; i++) begin
      @(posedge clk) clr <= 1'h1;
      @(posedge clk) clr <= 1'h0;
      cz <= 11'h001 << i;
      @(posedge clk) cz <= 11'h000;
      repeat (5) @(posedge clk);
      check_word(8'h16, {1'h1, (16'h0001 << czPos[i]) | ((i > 4 && i < 10) ? 16'h0080 : 16'h0000)});
    end
  endtask
  task automatic pulse(input logic v, input logic [11:0] d);
    @(posedge clk);
    curVal <= !v;
    volVal <= v;
    curIn <= d[7:0];
    volIn <= d;
    @(posedge clk);
    curVal <= 1'h0;
    volVal <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_average();
    repeat (4) pulse(1'h0, 12'hFFF);
    check_word(8'h1A, 17'h1003F);
    repeat (16) pulse(1'h0, 12'h080);
    check_word(8'h1A, 17'h10080);
    repeat (8) pulse(1'h1, 12'hFFF);
    check_word(8'h1C, 17'h107FF);
  endtask
  task automatic t_intr();
    st <= 11'h209;
    mask <= 7'h41;
    repeat (4) @(posedge clk);
    check_word(8'h18, 17'h14141);
    mask <= 7'h08;
    check_word(8'h18, 17'h10808);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, clr, curVal, volVal, st, cz, mask, curIn, volIn} = {1'h1, 52'h0};
    dac = 16'hA55A;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    t_status();
    t_latched();
    t_average();
    t_intr();
    end_of_test();
  end
  initial begin
    #50000;
    err_total++;
    end_of_test();
  end
endmodule // test_trb_telemetry_bank
`default_nettype wire
